// ==== rtl/adc_calibration_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "adc_cal_cfg.svh"

module adc_calibration_regs #(
  parameter int SAMPLE_CYCLES = `CAL_SAMPLE_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        acc_start,
  input  wire logic [2:0]  acc_reg,
  input  wire logic        acc_write,
  input  wire logic        acc_byte_valid,
  input  wire logic [7:0]  acc_wdata,
  input  wire logic        acc_end,
  input  wire logic        conv_valid,
  input  wire logic [23:0] conv_raw,
  input  wire logic [23:0] cal_zero_in,
  input  wire logic [23:0] cal_pos_in,
  input  wire logic [23:0] cal_neg_in,
  output var  logic [7:0]  acc_rdata,
  output var  logic        result_valid_n,
  output var  logic [2:0]  gain_sel,
  output var  logic [2:0]  op_mode,
  output var  logic        standby,
  output var  logic        cal_busy
);
  localparam int W = 24;

  cal_if cal ();

  logic [W-1:0] ctrl_reg;
  logic [W-1:0] ctrl_next;
  logic [W-1:0] coef_reg [3];
  logic [W-1:0] cal_val  [3];
  logic [W-1:0] data_reg;
  logic [W-1:0] pend_reg;
  logic         pend_v_reg;
  logic [1:0]   ptr_reg;
  logic         active_reg;
  logic         write_reg;
  logic [2:0]   sel_reg;
  logic         hi_wr_reg;
  logic         boot_reg;
  logic         start_reg;
  logic         busy_reg;
  logic         rvn_reg;
  logic         rvn_next;
  logic [7:0]   rdata_reg;
  logic         corr_valid;
  logic [W-1:0] corr_data;

  // control fields
  wire logic       bd        = ctrl_reg[`BYTE_DIR_BIT];
  wire logic [2:0] mode_f    = ctrl_reg[`MODE_LSB +: 3];
  wire logic       standby_f = ctrl_reg[`STANDBY_BIT];
  wire logic       is_cal    =
    mode_f >= 3'(adc_cal_pkg::MODE_SELF_CAL) &&
    mode_f <= 3'(adc_cal_pkg::MODE_SYS_NEG);

  // access decode
  wire logic byte_wr  = active_reg && write_reg && acc_byte_valid;
  wire logic [W-1:0] lane = 24'h0000FF << {ptr_reg, 3'b000};
  wire logic [W-1:0] wfill = {3{acc_wdata}};
  wire logic ctrl_wr    = byte_wr && sel_reg == adc_cal_pkg::SEL_CTRL;
  wire logic ctrl_hi_wr = ctrl_wr && ptr_reg != 2'h0;
  wire logic end_hi     = acc_end && active_reg && hi_wr_reg;
  wire logic start_next = boot_reg || (end_hi && is_cal);
  wire logic reading    =
    active_reg && !write_reg && sel_reg == adc_cal_pkg::SEL_DATA;
  wire logic data_rd_end = acc_end && reading;
  wire logic reading_now = reading && !acc_end;

  // read selection
  wire logic [W-1:0] rd_word =
    (sel_reg == adc_cal_pkg::SEL_CTRL)   ? ctrl_reg    :
    (sel_reg == adc_cal_pkg::SEL_DATA)   ? data_reg    :
    (sel_reg == adc_cal_pkg::SEL_OFFSET) ? coef_reg[0] :
    (sel_reg == adc_cal_pkg::SEL_POS)    ? coef_reg[1] :
    (sel_reg == adc_cal_pkg::SEL_NEG)    ? coef_reg[2] : '0;
  wire logic [7:0] rd_byte = (ptr_reg == 2'h3) ? 8'h00 :
                             rd_word[{ptr_reg, 3'b000} +: 8];

  // ready forced high during a high control byte write, in standby and while calibration owns the converter
  wire logic hold_hi =
    ctrl_hi_wr || standby_f || boot_reg || start_reg || cal.busy;
  wire logic take = corr_valid && !hold_hi;

  // control word byte merge
  assign ctrl_next = ctrl_wr ? (ctrl_reg & ~lane) | (wfill & lane)
                             : ctrl_reg;

  // ready flag: a new result wins over the read that clears it
  always_comb begin
    rvn_next = rvn_reg;
    if (hold_hi)                        rvn_next = 1'b1;
    else if (take)                      rvn_next = 1'b0;
    else if (data_rd_end && pend_v_reg) rvn_next = 1'b0;
    else if (data_rd_end)               rvn_next = 1'b1;
  end

  // control register, reset selects self calibration
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) ctrl_reg <= `CTRL_RESET;
    else          ctrl_reg <= ctrl_next;
  end

  // access framing and byte pointer
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      active_reg <= 1'b0;
      write_reg  <= 1'b0;
      sel_reg    <= '0;
      ptr_reg    <= 2'h2;
    end else if (acc_start) begin
      active_reg <= 1'b1;
      write_reg  <= acc_write;
      sel_reg    <= acc_reg;
      ptr_reg    <= bd ? 2'h0 : 2'h2;
    end else begin
      if (acc_end) active_reg <= 1'b0;
      if (active_reg && acc_byte_valid)
        ptr_reg <= bd ? ptr_reg + 2'h1 : ptr_reg - 2'h1;
    end
  end

  // high control byte tracking; byte 0 alone does not count
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)       hi_wr_reg <= 1'b0;
    else if (acc_start) hi_wr_reg <= 1'b0;
    else if (ctrl_hi_wr) hi_wr_reg <= 1'b1;
  end

  // calibration launch at reset release and after a high control byte write that selects a calibration mode
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      boot_reg  <= 1'b1;
      start_reg <= 1'b0;
      busy_reg  <= 1'b0;
    end else begin
      boot_reg  <= 1'b0;
      start_reg <= start_next;
      busy_reg  <= cal.busy || start_reg;
    end
  end

  assign cal.start = start_reg;
  assign cal.mode  = boot_reg ? 3'(adc_cal_pkg::MODE_SELF_CAL) : mode_f;
  assign cal_val[0] = cal.offset;
  assign cal_val[1] = cal.pos;
  assign cal_val[2] = cal.neg;

  // correction registers: offset, positive and negative scale
  for (genvar g = 0; g < 3; g++) begin : g_coef
    wire logic hit =
      byte_wr && sel_reg == 3'(32'(adc_cal_pkg::SEL_OFFSET) + g);
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n)
        coef_reg[g] <= '0;
      else if (cal.done && cal.load[g])
        coef_reg[g] <= cal_val[g];
      else if (hit)
        coef_reg[g] <= (coef_reg[g] & ~lane) | (wfill & lane);
    end
  end

  // result register with one spare word while a read is in flight
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      data_reg   <= '0;
      pend_reg   <= '0;
      pend_v_reg <= 1'b0;
    end else if (take && !reading_now) begin
      data_reg   <= corr_data;
      pend_v_reg <= 1'b0;
    end else if (take) begin
      pend_reg   <= corr_data;
      pend_v_reg <= 1'b1;
    end else if (data_rd_end && pend_v_reg) begin
      data_reg   <= pend_reg;
      pend_v_reg <= 1'b0;
    end
  end

  // outputs
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rvn_reg   <= 1'b1;
      rdata_reg <= '0;
    end else begin
      rvn_reg   <= rvn_next;
      rdata_reg <= rd_byte;
    end
  end

  assign result_valid_n = rvn_reg;
  assign acc_rdata      = rdata_reg;
  assign gain_sel       = ctrl_reg[`GAIN_LSB +: 3];
  assign op_mode        = mode_f;
  assign standby        = standby_f;
  assign cal_busy       = busy_reg;

  cal_engine #(
    .SAMPLE_CYCLES (SAMPLE_CYCLES)
  ) u_cal (
    .clk     (clk),
    .reset_n (reset_n),
    .cal     (cal.engine),
    .zero_in (cal_zero_in),
    .pos_in  (cal_pos_in),
    .neg_in  (cal_neg_in)
  );

  signal_correct #(
    .W (W)
  ) u_corr (
    .clk       (clk),
    .reset_n   (reset_n),
    .in_valid  (conv_valid),
    .raw       (conv_raw),
    .offset    (coef_reg[0]),
    .pos_coef  (coef_reg[1]),
    .neg_coef  (coef_reg[2]),
    .out_valid (corr_valid),
    .out_data  (corr_data)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  chk_hi_byte_ready: assert property (
    ctrl_hi_wr |=> result_valid_n)
    else $error("high control byte write left ready low");

  chk_recal_launch: assert property (
    end_hi && is_cal |=> start_reg ##1 busy_reg ##1 busy_reg)
    else $error("mode write did not restart calibration");

  chk_gain_only: assert property (
    acc_end && active_reg && !hi_wr_reg && !boot_reg |=> !start_reg)
    else $error("byte 0 write started calibration");

  chk_cal_blocks_ready: assert property (
    busy_reg |-> result_valid_n)
    else $error("ready low during calibration");

  chk_boot_cal: assert property (
    boot_reg |=> start_reg ##2 cal.busy)
    else $error("no self calibration after reset");

  chk_boot_mode: assert property (
    boot_reg |-> mode_f == adc_cal_pkg::MODE_SELF_CAL && !bd)
    else $error("reset mode or byte order wrong");

  chk_coef_load: assert property (
    cal.done && cal.load[1] |=> coef_reg[1] == $past(cal.pos))
    else $error("positive coefficient not loaded");

  chk_offset_byte: assert property (
    byte_wr && sel_reg == adc_cal_pkg::SEL_OFFSET && ptr_reg == 2'h2 &&
    !cal.done |=> coef_reg[0][23:16] == $past(acc_wdata))
    else $error("offset top byte not written");

  chk_byte_order: assert property (
    acc_start |=> ptr_reg == ($past(bd) ? 2'h0 : 2'h2))
    else $error("byte pointer start wrong");

  chk_ready_cause: assert property (
    $fell(result_valid_n) |-> $past(corr_valid) || $past(data_rd_end))
    else $error("ready fell without a result");

  cov_recal: cover property (end_hi && is_cal ##1 start_reg);
  cov_gain_only: cover property (ctrl_wr && ptr_reg == 2'h0 ##1 acc_end);
  cov_result: cover property ($fell(result_valid_n));
  cov_pend: cover property (data_rd_end && pend_v_reg);
endmodule : adc_calibration_regs

`default_nettype wire

// ==== common/adc_cal_cfg.svh ====
`ifndef ADC_CAL_CFG_SVH
`define ADC_CAL_CFG_SVH

// control word after reset: self calibration mode, bipolar
`define CTRL_RESET        24'h000300
// control field positions
`define MODE_LSB          9
`define BIPOLAR_BIT       8
`define GAIN_LSB          5
`define STANDBY_BIT       3
`define BYTE_DIR_BIT      2
// calibration timing and scaling
`define CAL_SAMPLE_CYCLES 16
`define CAL_FS_TARGET     24'h7FFFFF
`define COEF_FRAC_BITS    22

`endif

// ==== common/adc_cal_pkg.sv ====
`default_nettype none

package adc_cal_pkg;

  // operating mode field values
  typedef enum logic [2:0] {
    MODE_CONVERT    = 3'h0,
    MODE_SELF_CAL   = 3'h1,
    MODE_SYS_OFFSET = 3'h2,
    MODE_SYS_POS    = 3'h3,
    MODE_SYS_NEG    = 3'h4
  } op_mode_t;

  // register select codes on the access port
  typedef enum logic [2:0] {
    SEL_CTRL   = 3'h0,
    SEL_DATA   = 3'h1,
    SEL_OFFSET = 3'h2,
    SEL_POS    = 3'h3,
    SEL_NEG    = 3'h4
  } reg_sel_t;

  // calibration sequencer states
  typedef enum logic [2:0] {
    CAL_IDLE    = 3'h0,
    CAL_SAMPLE  = 3'h1,
    CAL_DIV_POS = 3'h2,
    CAL_DIV_NEG = 3'h3,
    CAL_DONE    = 3'h4
  } cal_state_t;

endpackage : adc_cal_pkg

`default_nettype wire

// ==== common/cal_if.sv ====
`timescale 1ns/1ps
`default_nettype none

interface cal_if;
  logic        start;
  logic [2:0]  mode;
  logic        busy;
  logic        done;
  logic [2:0]  load;
  logic [23:0] offset;
  logic [23:0] pos;
  logic [23:0] neg;

  modport ctrl   (output start, mode,
                  input  busy, done, load, offset, pos, neg);
  modport engine (input  start, mode,
                  output busy, done, load, offset, pos, neg);
endinterface : cal_if

`default_nettype wire

// ==== rtl/signal_correct.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "adc_cal_cfg.svh"

module signal_correct #(
  parameter int W = 24
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] raw,
  input  wire logic [W-1:0] offset,
  input  wire logic [W-1:0] pos_coef,
  input  wire logic [W-1:0] neg_coef,
  output var  logic         out_valid,
  output var  logic [W-1:0] out_data
);
  if (W < 8 || W > 32) $error("signal_correct: width out of range");

  localparam logic signed [2*W+1:0] MAX_P = {{(W+3){1'b0}}, {(W-1){1'b1}}};
  localparam logic signed [2*W+1:0] MIN_N = {{(W+3){1'b1}}, {(W-1){1'b0}}};

  // remove offset, then scale by the slope of the input's sign
  wire logic signed [W:0] centered =
    $signed({raw[W-1], raw}) - $signed({offset[W-1], offset});
  wire logic [W-1:0] coef = centered[W] ? neg_coef : pos_coef;
  wire logic signed [2*W+1:0] prod = centered * $signed({1'b0, coef});
  wire logic signed [2*W+1:0] scaled = prod >>> `COEF_FRAC_BITS;
  wire logic [W-1:0] sat = (scaled > MAX_P) ? MAX_P[W-1:0] :
                           (scaled < MIN_N) ? MIN_N[W-1:0] : scaled[W-1:0];

  // one register stage
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end else begin
      out_valid <= in_valid;
      out_data  <= sat;
    end
  end

  chk_zero_offset: assert property (@(posedge clk) disable iff (!reset_n)
    in_valid && raw == offset |=> out_valid && out_data == '0)
    else $error("input at offset did not give zero");
endmodule : signal_correct

`default_nettype wire

// ==== rtl/cal_engine.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "adc_cal_cfg.svh"

module cal_engine #(
  parameter int SAMPLE_CYCLES = `CAL_SAMPLE_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  cal_if.engine            cal,
  input  wire logic [23:0] zero_in,
  input  wire logic [23:0] pos_in,
  input  wire logic [23:0] neg_in
);
  if (SAMPLE_CYCLES < 1 || SAMPLE_CYCLES > 65535)
    $error("cal_engine: sample count out of range");

  localparam int NB = 46;

  adc_cal_pkg::cal_state_t state_reg;
  adc_cal_pkg::cal_state_t state_next;
  logic [15:0]   cnt_reg;
  logic [5:0]    bit_reg;
  logic [24:0]   rem_reg;
  logic [NB-1:0] quo_reg;
  logic [23:0]   span_reg;
  logic [23:0]   nraw_reg;
  logic [23:0]   zero_reg;
  logic [23:0]   pos_reg;
  logic [23:0]   neg_reg;
  logic [2:0]    load_reg;

  // long division of the full-scale target by the measured span
  wire logic [NB-1:0] num     = {`CAL_FS_TARGET, 22'h0};
  wire logic [24:0]   trial   = {rem_reg[23:0], num[bit_reg]};
  wire logic          fit     = trial >= {1'b0, span_reg};
  wire logic [NB-1:0] quo_fin = {quo_reg[NB-2:0], fit};
  wire logic [23:0]   quo_sat = (|quo_fin[NB-1:24]) ? 24'hFFFFFF
                                                    : quo_fin[23:0];
  wire logic last_bit   = bit_reg == 6'h0;
  wire logic sample_end = cnt_reg == 16'(SAMPLE_CYCLES - 1);
  wire logic [2:0] mask =
    (cal.mode == adc_cal_pkg::MODE_SYS_OFFSET) ? 3'h1 :
    (cal.mode == adc_cal_pkg::MODE_SYS_POS)    ? 3'h2 :
    (cal.mode == adc_cal_pkg::MODE_SYS_NEG)    ? 3'h4 : 3'h7;

  // sequencer: a new start restarts from sampling
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      adc_cal_pkg::CAL_IDLE:    state_next = state_reg;
      adc_cal_pkg::CAL_SAMPLE:
        if (sample_end) state_next = adc_cal_pkg::CAL_DIV_POS;
      adc_cal_pkg::CAL_DIV_POS:
        if (last_bit) state_next = adc_cal_pkg::CAL_DIV_NEG;
      adc_cal_pkg::CAL_DIV_NEG:
        if (last_bit) state_next = adc_cal_pkg::CAL_DONE;
      default:        state_next = adc_cal_pkg::CAL_IDLE;
    endcase
    if (cal.start) state_next = adc_cal_pkg::CAL_SAMPLE;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) state_reg <= adc_cal_pkg::CAL_IDLE;
    else          state_reg <= state_next;
  end

  // sample capture and division datapath
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_reg  <= '0;
      bit_reg  <= '0;
      rem_reg  <= '0;
      quo_reg  <= '0;
      span_reg <= '0;
      nraw_reg <= '0;
      zero_reg <= '0;
      pos_reg  <= '0;
      neg_reg  <= '0;
      load_reg <= '0;
    end else if (cal.start) begin
      cnt_reg  <= '0;
      load_reg <= mask;
    end else if (state_reg == adc_cal_pkg::CAL_SAMPLE) begin
      cnt_reg <= cnt_reg + 16'h1;
      if (sample_end) begin
        zero_reg <= zero_in;
        nraw_reg <= neg_in;
        span_reg <= pos_in - zero_in;
        bit_reg  <= 6'(NB - 1);
        rem_reg  <= '0;
        quo_reg  <= '0;
      end
    end else if (state_reg == adc_cal_pkg::CAL_DIV_POS ||
                 state_reg == adc_cal_pkg::CAL_DIV_NEG) begin
      rem_reg <= fit ? trial - {1'b0, span_reg} : trial;
      quo_reg <= quo_fin;
      bit_reg <= bit_reg - 6'h1;
      if (last_bit && state_reg == adc_cal_pkg::CAL_DIV_POS) begin
        pos_reg  <= quo_sat;
        span_reg <= zero_reg - nraw_reg;
        bit_reg  <= 6'(NB - 1);
        rem_reg  <= '0;
        quo_reg  <= '0;
      end else if (last_bit) begin
        neg_reg <= quo_sat;
      end
    end
  end

  assign cal.busy   = state_reg != adc_cal_pkg::CAL_IDLE;
  assign cal.done   = state_reg == adc_cal_pkg::CAL_DONE;
  assign cal.load   = load_reg;
  assign cal.offset = zero_reg;
  assign cal.pos    = pos_reg;
  assign cal.neg    = neg_reg;

  chk_start_sample: assert property (@(posedge clk) disable iff (!reset_n)
    cal.start |=> state_reg == adc_cal_pkg::CAL_SAMPLE && cnt_reg == '0)
    else $error("start did not begin sampling");
endmodule : cal_engine

`default_nettype wire

// ==== sim/host_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module host_model (
  input  wire logic       clk,
  output var  logic       acc_start,
  output var  logic [2:0] acc_reg,
  output var  logic       acc_write,
  output var  logic       acc_byte_valid,
  output var  logic [7:0] acc_wdata,
  output var  logic       acc_end,
  input  wire logic [7:0] acc_rdata
);
  // idle port after power-up
  initial begin
    {acc_start, acc_write, acc_byte_valid, acc_end} = 4'h0;
    acc_reg   = 3'h7;
    acc_wdata = 8'h00;
  end

  // one access: open, n bytes in wire order, close
  // bytes go 2,1,0 or 0,1,2 as the host's byte order bit says
  task automatic xfer(input logic [2:0] sel, input logic wr,
                      input logic asc, input int n,
                      input logic [23:0] wd, output logic [23:0] rd);
    int k;
    rd = 24'h000000;
    @(negedge clk);
    acc_start = 1'b1;
    acc_reg   = sel;
    acc_write = wr;
    @(negedge clk);
    acc_start = 1'b0;
    acc_reg   = ~sel; // select only counts at the opening edge
    for (int i = 0; i < n; i++) begin
      k = asc ? i : 2 - i;
      if (!wr) begin
        @(negedge clk);
        rd[8*k +: 8] = acc_rdata;
      end
      acc_byte_valid = 1'b1;
      acc_wdata      = wd[8*k +: 8];
      @(negedge clk);
      if (!wr) acc_byte_valid = 1'b0;
    end
    if (wr) acc_byte_valid = 1'b0;
    acc_wdata = ~acc_wdata; // released data is not left stale
    @(negedge clk);
    acc_end = 1'b1;
    @(negedge clk);
    acc_end = 1'b0;
  endtask : xfer
endmodule : host_model

`default_nettype wire

// ==== sim/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "adc_cal_cfg.svh"

module testbench;
  localparam int SC = 2;
  logic        clk, reset_n, conv_valid, asc_q;
  logic        acc_start, acc_write, acc_byte_valid, acc_end;
  logic        result_valid_n, standby, cal_busy;
  logic [2:0]  acc_reg, gain_sel, op_mode;
  logic [7:0]  acc_wdata, acc_rdata;
  logic [23:0] conv_raw, cz, cp, cn, rd, off, pc, nc, v;
  int          error_cnt = 0;
  int          comparisons = 0;

  adc_calibration_regs #(.SAMPLE_CYCLES(SC)) i_adc_calibration_regs (
    .clk(clk), .reset_n(reset_n), .acc_start(acc_start),
    .acc_reg(acc_reg), .acc_write(acc_write),
    .acc_byte_valid(acc_byte_valid), .acc_wdata(acc_wdata),
    .acc_end(acc_end), .conv_valid(conv_valid), .conv_raw(conv_raw),
    .cal_zero_in(cz), .cal_pos_in(cp), .cal_neg_in(cn),
    .acc_rdata(acc_rdata), .result_valid_n(result_valid_n),
    .gain_sel(gain_sel), .op_mode(op_mode), .standby(standby),
    .cal_busy(cal_busy));

  host_model i_host_model (
    .clk(clk), .acc_start(acc_start), .acc_reg(acc_reg),
    .acc_write(acc_write), .acc_byte_valid(acc_byte_valid),
    .acc_wdata(acc_wdata), .acc_end(acc_end), .acc_rdata(acc_rdata));

  // clock and watchdog
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    #(20000 * 40);
    error_cnt++;
    give_verdict();
  end

  // expected coefficient from two calibration levels
  function automatic logic [23:0] coef(input logic [23:0] a, b);
    logic signed [24:0] d;
    logic        [47:0] q;
    d = $signed({b[23], b}) - $signed({a[23], a});
    q = {24'h7FFFFF, 22'h000000} / {23'h000000, d};
    return (q > 48'hFFFFFF) ? 24'hFFFFFF : q[23:0];
  endfunction : coef

  // expected corrected result, saturating
  function automatic logic [23:0] corr(input logic [23:0] r);
    logic signed [24:0] d;
    logic signed [49:0] s;
    d = $signed({r[23], r}) - $signed({off[23], off});
    s = (d * $signed({1'b0, (d < 0) ? nc : pc})) >>> 22;
    if (s > 50'sh7FFFFF) return 24'h7FFFFF;
    if (s < -50'sh800000) return 24'h800000;
    return s[23:0];
  endfunction : corr

  function automatic logic [23:0] ctl(input logic [2:0] m, g,
                                      input logic a);
    return (24'h1 << `BIPOLAR_BIT) | (24'(m) << `MODE_LSB)
         | (24'(g) << `GAIN_LSB) | (24'(a) << `BYTE_DIR_BIT);
  endfunction : ctl

  task automatic check(input logic [23:0] got, exp, input string s);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h exp %h", $time, s, got, exp);
    end
  endtask : check

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict

  // new random calibration levels and their expected coefficients
  task automatic new_levels;
    cz  = 24'($urandom_range(0, 24'h00FFFF));
    cp  = cz + 24'h400000 + 24'($urandom_range(0, 24'h0FFFFF));
    cn  = cz - 24'h400000 - 24'($urandom_range(0, 24'h0FFFFF));
    off = cz;
    pc  = coef(cz, cp);
    nc  = coef(cn, cz);
  endtask : new_levels

  // calibration must start, keep ready high and finish in bounds
  task automatic cal_run;
    int   t;
    logic low;
    t   = 0;
    low = 1'b0;
    while (cal_busy !== 1'b1 && t < 10) begin
      @(negedge clk);
      t++;
    end
    check({23'h0, cal_busy}, 24'h1, "calibration start");
    t = 0;
    conv_valid = 1'b1;
    @(negedge clk);
    conv_valid = 1'b0;
    while (cal_busy === 1'b1 && t < 400) begin
      @(negedge clk);
      t++;
      low |= (result_valid_n !== 1'b1);
    end
    check({23'h0, cal_busy | low}, 24'h0, "calibration ready");
    repeat (3) @(negedge clk);
  endtask : cal_run

  task automatic conv_pulse(input logic [23:0] r);
    conv_raw   = r;
    conv_valid = 1'b1;
    @(negedge clk);
    conv_valid = 1'b0;
    conv_raw   = ~r;
    repeat (2) @(negedge clk);
    check({23'h0, result_valid_n}, 24'h0, "ready low");
  endtask : conv_pulse

  task automatic convert(input logic [23:0] r);
    conv_pulse(r);
    i_host_model.xfer(3'(adc_cal_pkg::SEL_DATA), 1'b0, asc_q, 3,
                      24'h0, rd);
    check(rd, corr(r), "corrected result");
    @(negedge clk);
    check({23'h0, result_valid_n}, 24'h1, "ready after read");
  endtask : convert

  task automatic coefs_ok;
    i_host_model.xfer(3'(adc_cal_pkg::SEL_OFFSET), 1'b0, asc_q, 3,
                      24'h0, rd);
    check(rd, cz, "offset");
    i_host_model.xfer(3'(adc_cal_pkg::SEL_POS), 1'b0, asc_q, 3,
                      24'h0, rd);
    check(rd, pc, "pos coef");
    i_host_model.xfer(3'(adc_cal_pkg::SEL_NEG), 1'b0, asc_q, 3,
                      24'h0, rd);
    check(rd, nc, "neg coef");
  endtask : coefs_ok

  task automatic wr_ctl(input logic [23:0] d, input int n);
    i_host_model.xfer(3'(adc_cal_pkg::SEL_CTRL), 1'b1, asc_q, n, d, rd);
  endtask : wr_ctl

  // main sequence
  initial begin
    reset_n    = 1'b0;
    conv_valid = 1'b0;
    conv_raw   = 24'h000000;
    asc_q      = 1'b0;
    v          = 24'($urandom(32'h2648EFD2));
    new_levels();
    repeat (2) @(negedge clk);
    check({21'h0, op_mode}, 24'h1, "reset mode");
    reset_n = 1'b1;
    cal_run();
    i_host_model.xfer(3'h0, 1'b0, 1'b0, 3, 24'h0, rd);
    check(rd, `CTRL_RESET, "ctrl reset");
    coefs_ok();
    $display("test boot done");
    for (int i = 0; i < 5; i++) convert(i == 0 ? cz : 24'($urandom()));
    // a result arriving mid-read parks in the spare word
    conv_pulse(24'h000777);
    fork
      i_host_model.xfer(3'(adc_cal_pkg::SEL_DATA), 1'b0, asc_q, 3,
                        24'h0, rd);
      begin
        repeat (3) @(negedge clk);
        conv_raw   = 24'h000999;
        conv_valid = 1'b1;
        @(negedge clk);
        conv_valid = 1'b0;
      end
    join
    check(rd, corr(24'h000777), "read kept");
    check({23'h0, result_valid_n}, 24'h0, "spare ready");
    i_host_model.xfer(3'(adc_cal_pkg::SEL_DATA), 1'b0, asc_q, 3,
                      24'h0, rd);
    check(rd, corr(24'h000999), "spare word");
    $display("test convert done");
    conv_pulse(24'h012345);
    wr_ctl(ctl(3'h0, 3'h0, 1'b1), 3);
    check({23'h0, result_valid_n}, 24'h1, "high byte write");
    asc_q = 1'b1;
    conv_pulse(24'h054321);
    wr_ctl(ctl(3'h0, 3'h5, 1'b1), 1);
    repeat (6) @(negedge clk);
    check({23'h0, result_valid_n | cal_busy}, 24'h0, "byte 0");
    check({21'h0, gain_sel}, 24'h5, "gain");
    new_levels();
    wr_ctl(ctl(3'h1, 3'h5, 1'b1), 3);
    check({23'h0, result_valid_n}, 24'h1, "recal write");
    cal_run();
    coefs_ok();
    for (int m = 2; m < 5; m++) begin
      wr_ctl(ctl(3'(m), 3'h5, 1'b1), 3);
      check({21'h0, op_mode}, 24'(m), "mode");
      cal_run();
    end
    // standby keeps ready high even when a result arrives
    wr_ctl(ctl(3'h0, 3'h5, 1'b1) | (24'h1 << `STANDBY_BIT), 3);
    conv_raw   = 24'h000123;
    conv_valid = 1'b1;
    @(negedge clk);
    conv_valid = 1'b0;
    repeat (2) @(negedge clk);
    check({22'h0, standby, result_valid_n}, 24'h3, "standby");
    wr_ctl(ctl(3'h0, 3'h5, 1'b1), 3);
    check({23'h0, standby}, 24'h0, "standby off");
    $display("test control done");
    for (int j = 0; j < 3; j++) begin
      v = 24'($urandom_range(0, 24'h3FFFFF));
      if (j == 0) off = v;
      else if (j == 1) pc = v;
      else nc = v;
      i_host_model.xfer(3'(2 + j), 1'b1, 1'b1, 3, v, rd);
      i_host_model.xfer(3'(2 + j), 1'b0, 1'b1, 3, 24'h0, rd);
      check(rd, v, "coef readback");
      convert(off + 24'h001234);
      convert(off - 24'h001234);
    end
    i_host_model.xfer(3'h5, 1'b1, 1'b1, 3, 24'hA5A5A5, rd);
    i_host_model.xfer(3'h5, 1'b0, 1'b1, 3, 24'h0, rd);
    check(rd, 24'h000000, "unmapped");
    $display("test registers done");
    new_levels();
    reset_n = 1'b0;
    @(negedge clk);
    check({17'h0, result_valid_n, gain_sel, op_mode}, 24'h41,
          "reset");
    reset_n = 1'b1;
    asc_q   = 1'b0;
    cal_run();
    i_host_model.xfer(3'h0, 1'b0, 1'b0, 3, 24'h0, rd);
    check(rd, `CTRL_RESET, "ctrl after reset");
    coefs_ok();
    $display("test reset done");
    give_verdict();
  end
endmodule : testbench

`default_nettype wire
